// ---- shared/autotune_pkg.sv ----
/*
 shared constants of the auto-tuning controller: register map, parameter
 numbers, tuning state codes, phase timing.
 assumes a 25 MHz pclk and a 32-bit apb master.
*/
package autotune_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_off    = 8'h00;
   localparam logic [7:0] status_off  = 8'h04;
   localparam logic [7:0] irq_st_off  = 8'h08;
   localparam logic [7:0] irq_msk_off = 8'h0c;
   localparam logic [7:0] par_adr_off = 8'h10;
   localparam logic [7:0] par_dat_off = 8'h14;
   localparam logic [7:0] tune_off    = 8'h18;
   localparam logic [7:0] src_off     = 8'h1c;
   localparam logic [7:0] wprot_off   = 8'h20;
   localparam logic [7:0] led_off     = 8'h24;
   localparam logic [7:0] mon_off     = 8'h28;

   // tuning state codes
   localparam logic [3:0] ts_off      = 4'h0;
   localparam logic [3:0] ts_armed    = 4'h1;
   localparam logic [3:0] ts_running  = 4'h2;
   localparam logic [3:0] ts_done     = 4'h3;
   localparam logic [3:0] ts_forced   = 4'h8;
   localparam logic [3:0] ts_error    = 4'h9;

   localparam logic [1:0] src_auto    = 2'h0;
   localparam logic [1:0] src_direct1 = 2'h1;
   localparam logic [1:0] src_direct2 = 2'h2;
   localparam logic [1:0] src_builtin = 2'h3;

   localparam logic [15:0] unlock_code = 16'h0321;
   localparam logic [7:0]  const_last  = 8'h05;
   localparam logic [7:0]  mfr_first   = 8'h06;
   localparam logic [7:0]  data_first  = 8'h29;
   localparam logic [7:0]  data_last   = 8'h2f;
   localparam logic [1:0]  led_show    = 2'h1;

   // ctrl bit positions
   localparam int ctl_ext_bit   = 0;
   localparam int ctl_fault_bit = 1;
   localparam int ctl_freq_bit  = 2;
   localparam int ctl_rated_bit = 3;

   // irq bit positions
   localparam int irq_done_bit  = 0;
   localparam int irq_fail_bit  = 1;

   localparam int clk_khz         = 25000;
   localparam int ramp_pct        = 75;
   localparam int const_speed_ms  = 5000;
   localparam int const_speed_cyc = clk_khz * const_speed_ms;
   localparam int excite_ms       = 500;
   localparam int excite_cyc      = clk_khz * excite_ms;
   localparam int ramp_ms         = 1000;
   localparam int ramp_cyc        = clk_khz * ramp_ms;

   typedef enum logic [6:0] {
      ph_idle  = 7'b0000001,
      ph_ac    = 7'b0000010,
      ph_dc    = 7'b0000100,
      ph_accel = 7'b0001000,
      ph_hold  = 7'b0010000,
      ph_decel = 7'b0100000,
      ph_end   = 7'b1000000
   } phase_t;
endpackage

// ---- logic/tune_data_ram.sv ----
/*
 eight-entry store of tuning data words (slots 41 to 47, entry 0 unused).
 assumes one write port and a registered read on the same pclk.
*/
`timescale 1ns/1ps
module tune_data_ram
#(
   parameter int width = 16,
   parameter int depth = 8
)
(
   input  wire logic                     pclk,
   input  wire logic                     we,
   input  wire logic [$clog2(depth)-1:0] waddr,
   input  wire logic [width-1:0]         wdata,
   input  wire logic [$clog2(depth)-1:0] raddr,
   output logic      [width-1:0]         rdata_ff
);
   logic [width-1:0] mem [depth];

   // no reset on storage: contents survive a soft reset
   always_ff @(posedge pclk)
   begin
      if (we)
         mem[waddr] <= wdata;
      rdata_ff <= mem[raddr];
   end
endmodule

// ---- logic/phase_timer.sv ----
/*
 down counter timing each tuning phase; pulses done when the load expires.
 assumes load and count arrive from logic on pclk.
*/
`timescale 1ns/1ps
module phase_timer
#(
   parameter int width = 32
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             load,
   input  wire logic [width-1:0] count,
   input  wire logic             abort,
   output logic                  done_ff
);
   import autotune_pkg::*;
   logic [width-1:0] cnt_ff;
   logic             run_ff;
   wire              last = run_ff && (cnt_ff <= {{(width-1){1'b0}}, 1'b1});

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff  <= '0;
         run_ff  <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= last && !load && !abort;
         if (load)
         begin
            cnt_ff <= count;
            run_ff <= 1'b1;
         end
         else if (abort || last)
            run_ff <= 1'b0;
         else if (run_ff)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule

// ---- logic/autotune_ctrl.sv ----
/*
 auto-tuning controller: phase sequencer, tuning state code, locked
 parameter window, start terminal handling, apb register slave.
 assumes start and terminal inputs are asynchronous pins; apb on pclk.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module autotune_ctrl
   import autotune_pkg::*;
#(
   parameter int timer_w   = 32,
   parameter int hold_cyc  = const_speed_cyc,
   parameter int exc_cyc   = excite_cyc,
   parameter int rmp_cyc   = ramp_cyc,
   parameter int n_others  = 4
)
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata_ff,
   output logic                     pready_ff,
   output logic                     pslverr_ff,
   input  wire logic                forward_run_key,
   input  wire logic                reverse_run_key,
   input  wire logic                stop_key,
   input  wire logic                forward_start_input,
   input  wire logic                reverse_start_input,
   input  wire logic                external_thermal_trip_input,
   input  wire logic                output_shutoff_input,
   input  wire logic                fault_clear_input,
   input  wire logic [n_others-1:0] other_inputs,
   output logic                     run_ff,
   output logic                     reverse_ff,
   output logic                     tuning_ff,
   output logic      [6:0]          phase_ff,
   output logic      [7:0]          speed_ref_pct_ff,
   output logic                     const_write_ff,
   output logic                     banner_ff,
   output logic      [3:0]          led_code_ff,
   output logic                     led_on_ff,
   output logic      [n_others-1:0] other_valid_ff,
   output logic                     trip_ff,
   output logic                     shutoff_ff,
   output logic                     irq_ff
);
   //////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int npin = 8 + n_others;
   logic [npin-1:0] pin_s1_ff, pin_s2_ff, pin_d_ff;
   wire  [npin-1:0] pin_raw = {other_inputs, stop_key, fault_clear_input,
      output_shutoff_input, external_thermal_trip_input, reverse_start_input,
      forward_start_input, reverse_run_key, forward_run_key};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_d_ff  <= '0;
      end
      else
      begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
         pin_d_ff  <= pin_s2_ff;
      end
   end

   wire [npin-1:0] pin_rise = pin_s2_ff & ~pin_d_ff;
   wire fwd_key_p = pin_rise[0];
   wire rev_key_p = pin_rise[1];
   wire fwd_in    = pin_s2_ff[2];
   wire rev_in    = pin_s2_ff[3];
   wire thermal   = pin_s2_ff[4];
   wire shutoff   = pin_s2_ff[5];
   wire clear_p   = pin_rise[6];
   wire stop_p    = pin_rise[7];
   wire [n_others-1:0] others = pin_s2_ff[npin-1:8];

   //////////////////////////////////////////////////////////////////////
   // apb decode
   logic [3:0]  tune_ff;
   logic [1:0]  src_ff;
   logic [15:0] wprot_ff;
   logic [1:0]  led_ff;
   logic [3:0]  ctrl_ff;
   logic [1:0]  irq_st_ff, irq_msk_ff;
   logic [7:0]  par_adr_ff;
   logic [15:0] par_ord_ff [const_last+1];
   logic [15:0] par_mot_ff [const_last+1];
   logic [15:0] ram_rdata;

   wire acc     = psel && penable && !pready_ff;
   wire wr      = psel && penable && pready_ff && pwrite;
   wire unlock  = (wprot_ff == unlock_code);
   wire ext_md  = ctrl_ff[ctl_ext_bit];
   wire direct  = (src_ff == src_direct1) || (src_ff == src_direct2);
   wire in_const = (par_adr_ff <= const_last);
   wire in_data = (par_adr_ff >= data_first) && (par_adr_ff <= data_last);
   wire mfr_vis = unlock && (par_adr_ff >= mfr_first);
   wire use_mot = unlock && direct && in_const;
   wire use_dat = unlock && in_data;
   wire [2:0] cidx = par_adr_ff[2:0];
   wire [2:0] didx = 3'(par_adr_ff - data_first + 8'h01);
   wire par_hit = in_const || use_dat || mfr_vis;
   wire [15:0] par_rd = !in_const ? (use_dat ? ram_rdata : 16'h0000)
                        : use_mot ? par_mot_ff[cidx] : par_ord_ff[cidx];
   wire wr_pdat = wr && (paddr == par_dat_off) && par_hit;
   // value 3 refused unless the window is unlocked
   wire src_ok  = (pwdata[1:0] != src_builtin) || unlock;
   wire addr_ok = (paddr <= mon_off) && (paddr[1:0] == 2'b00);

   //////////////////////////////////////////////////////////////////////
   // tuning sequencer
   phase_t ph_ff, nxt_ph;
   logic   tmr_load, tmr_done;
   logic [timer_w-1:0] tmr_cnt;
   wire ratings = ctrl_ff[ctl_rated_bit];
   wire armed   = (tune_ff == ts_armed) && (src_ff == src_auto) && ratings;
   wire start_p = ext_md ? (pin_rise[2] || pin_rise[3])
                         : (fwd_key_p || rev_key_p);
   wire start_rev = ext_md ? rev_in : rev_key_p;
   wire fault   = ctrl_ff[ctl_fault_bit] || thermal;
   wire forced  = (ph_ff != ph_idle) && (ph_ff != ph_end) &&
                  (shutoff || (ext_md ? !(fwd_in || rev_in) : stop_p));
   wire release_run = ext_md ? !(fwd_in || rev_in) : stop_p;
   wire aborting = tuning_ff && (fault || forced);

   always_comb
   begin
      nxt_ph   = ph_ff;
      tmr_load = 1'b0;
      tmr_cnt  = '0;
      unique case (ph_ff)
         ph_idle:
            if (armed && start_p)
            begin
               nxt_ph   = ph_ac;
               tmr_load = 1'b1;
               tmr_cnt  = timer_w'(exc_cyc);
            end
         ph_ac:
            if (tmr_done)
            begin
               nxt_ph   = ph_dc;
               tmr_load = 1'b1;
               tmr_cnt  = timer_w'(exc_cyc);
            end
         ph_dc:
            if (tmr_done)
            begin
               nxt_ph   = ph_accel;
               tmr_load = 1'b1;
               tmr_cnt  = timer_w'(rmp_cyc);
            end
         ph_accel:
            if (tmr_done)
            begin
               nxt_ph   = ph_hold;
               tmr_load = 1'b1;
               tmr_cnt  = timer_w'(hold_cyc);
            end
         ph_hold:
            if (tmr_done)
            begin
               nxt_ph   = ph_decel;
               tmr_load = 1'b1;
               tmr_cnt  = timer_w'(rmp_cyc);
            end
         ph_decel:
            if (tmr_done)
               nxt_ph = ph_end;
         ph_end:
            if (release_run)
               nxt_ph = ph_idle;
      endcase
      if (aborting)
         nxt_ph = ph_end;
   end

   phase_timer #(.width(timer_w)) u_timer
   (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (tmr_load),
      .count   (tmr_cnt),
      .abort   (aborting),
      .done_ff (tmr_done)
   );

   // end-state code: forced wins over error when both hit
   wire [3:0] end_code = forced ? ts_forced : ts_error;
   wire ok_end  = (ph_ff == ph_decel) && tmr_done && !aborting;
   wire bad_end = aborting;
   wire [3:0] nxt_tune = (ph_ff == ph_idle && nxt_ph == ph_ac) ? ts_running
                       : ok_end ? ts_done
                       : bad_end ? end_code
                       : (wr && paddr == tune_off) ? pwdata[3:0] : tune_ff;
   // normal run whenever the start is not a tuning start
   wire normal_run = (ph_ff == ph_idle) && !armed &&
                     (ext_md ? (fwd_in || rev_in) : run_ff && !stop_p);
   wire normal_go  = (ph_ff == ph_idle) && !armed && !ext_md &&
                     (fwd_key_p || rev_key_p);

   //////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph_ff          <= ph_idle;
         tune_ff        <= ts_off;
         src_ff         <= src_auto;
         wprot_ff       <= '0;
         led_ff         <= led_show;
         ctrl_ff        <= '0;
         par_adr_ff     <= '0;
         run_ff         <= 1'b0;
         reverse_ff     <= 1'b0;
         const_write_ff <= 1'b0;
      end
      else
      begin
         ph_ff   <= nxt_ph;
         tune_ff <= nxt_tune;
         if (wr && paddr == src_off && src_ok)
            src_ff <= pwdata[1:0];
         if (wr && paddr == wprot_off)
            wprot_ff <= pwdata[15:0];
         if (wr && paddr == led_off)
            led_ff <= pwdata[1:0];
         if (wr && paddr == ctrl_off)
            ctrl_ff <= pwdata[3:0];
         if (wr && paddr == par_adr_off)
            par_adr_ff <= pwdata[7:0];
         run_ff <= (nxt_ph != ph_idle) || normal_run || normal_go;
         if (start_p)
            reverse_ff <= start_rev;
         const_write_ff <= ok_end;
      end
   end

   // ordinary and motor-constant banks kept apart
   for (genvar i = 0; i <= const_last; i++)
   begin : g_par
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            par_ord_ff[i] <= '0;
            par_mot_ff[i] <= '0;
         end
         else if (wr_pdat && cidx == 3'(i) && in_const)
         begin
            if (use_mot)
               par_mot_ff[i] <= pwdata[15:0];
            else
               par_ord_ff[i] <= pwdata[15:0];
         end
      end
   end

   tune_data_ram #(.width(16), .depth(8)) u_ram
   (
      .pclk     (pclk),
      .we       (wr_pdat && use_dat),
      .waddr    (didx),
      .wdata    (pwdata[15:0]),
      .raddr    (didx),
      .rdata_ff (ram_rdata)
   );

   //////////////////////////////////////////////////////////////////////
   // outputs and monitor
   wire [7:0] pct = (ph_ff == ph_hold) ? 8'(ramp_pct)
                  : (ph_ff == ph_accel || ph_ff == ph_decel) ? 8'(ramp_pct / 2)
                  : 8'h00;
   wire banner = tuning_ff && ctrl_ff[ctl_freq_bit];
   wire [1:0] ev = {bad_end, ok_end};
   wire [1:0] nxt_irq = (irq_st_ff | ev) &
                        ~((wr && paddr == irq_st_off) ? pwdata[1:0] & ~ev : 2'b00);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tuning_ff        <= 1'b0;
         phase_ff         <= ph_idle;
         speed_ref_pct_ff <= '0;
         banner_ff        <= 1'b0;
         led_code_ff      <= '0;
         led_on_ff        <= 1'b0;
         other_valid_ff   <= '0;
         trip_ff          <= 1'b0;
         shutoff_ff       <= 1'b0;
         irq_st_ff        <= '0;
         irq_msk_ff       <= '0;
         irq_ff           <= 1'b0;
      end
      else
      begin
         tuning_ff        <= (nxt_ph != ph_idle) && (nxt_ph != ph_end);
         phase_ff         <= nxt_ph;
         speed_ref_pct_ff <= pct;
         banner_ff        <= banner;
         led_code_ff      <= tune_ff;
         led_on_ff        <= (led_ff == led_show);
         other_valid_ff   <= tuning_ff ? '0 : others;
         trip_ff          <= thermal;
         shutoff_ff       <= shutoff;
         irq_st_ff        <= nxt_irq;
         if (wr && paddr == irq_msk_off)
            irq_msk_ff <= pwdata[1:0];
         irq_ff           <= |(nxt_irq & ~irq_msk_ff);
      end
   end
   // a fault clear rearms nothing here; its rising edge only shows in status bit 4
   wire clr_fault = clear_p;

   //////////////////////////////////////////////////////////////////////
   // apb answer
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      unique case (paddr)
         ctrl_off:    rd_mux = {28'h0, ctrl_ff};
         status_off:  rd_mux = {16'h0, 1'b0, ph_ff, unlock, run_ff, tuning_ff,
                                clr_fault, tune_ff};
         irq_st_off:  rd_mux = {30'h0, irq_st_ff};
         irq_msk_off: rd_mux = {30'h0, irq_msk_ff};
         par_adr_off: rd_mux = {24'h0, par_adr_ff};
         par_dat_off: rd_mux = {16'h0, par_rd};
         tune_off:    rd_mux = {28'h0, tune_ff};
         src_off:     rd_mux = {30'h0, src_ff};
         wprot_off:   rd_mux = {16'h0, wprot_ff};
         led_off:     rd_mux = {30'h0, led_ff};
         mon_off:     rd_mux = {20'h0, banner_ff, 3'h0, speed_ref_pct_ff};
         default:     rd_mux = '0;
      endcase
   end

   // one wait state so the data ram read is settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end
      else
      begin
         pready_ff  <= acc;
         pslverr_ff <= acc && !addr_ok;
         prdata_ff  <= (acc && !pwrite) ? rd_mux : '0;
      end
   end
endmodule

// ---- sim/autotune_ctrl_assertions.sv ----
/*
 checker for apb timing and tuning phase outputs of autotune_ctrl.
 bound to the top module; sees its ports only.
*/
`timescale 1ns/1ps
module autotune_ctrl_assertions
   import autotune_pkg::*;
#(
   parameter int n_others = 4
)
(
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pready_ff,
   input wire logic                pslverr_ff,
   input wire logic                tuning_ff,
   input wire logic [6:0]          phase_ff,
   input wire logic [7:0]          speed_ref_pct_ff,
   input wire logic                const_write_ff,
   input wire logic [3:0]          led_code_ff,
   input wire logic [n_others-1:0] other_valid_ff
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   sequence enter_dc;
      phase_ff == ph_dc && $past(phase_ff) != ph_dc;
   endsequence
   sequence enter_accel;
      phase_ff == ph_accel && $past(phase_ff) != ph_accel;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_apb_wait: assert property (psel && !penable |-> ##2 pready_ff)
      else $error("pready late after setup");
   chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr_ff |-> pready_ff)
      else $error("pslverr without pready");
   chk_other_mask: assert property (
      tuning_ff && $past(tuning_ff) |-> other_valid_ff == '0)
      else $error("other terminal live in tuning");
   chk_hold_speed: assert property (
      phase_ff == ph_hold ##1 phase_ff == ph_hold |-> speed_ref_pct_ff == 8'h4b)
      else $error("hold speed not 75");
   chk_tune_phase: assert property (tuning_ff |-> phase_ff != ph_idle)
      else $error("tuning while idle");
   chk_ac_dc: assert property (enter_dc |-> $past(phase_ff) == ph_ac)
      else $error("dc not after ac");
   chk_dc_accel: assert property (enter_accel |-> $past(phase_ff) == ph_dc)
      else $error("accel not after dc");
   chk_commit_done: assert property (
      const_write_ff |-> ##[0:2] led_code_ff == ts_done)
      else $error("commit without done");
endmodule

bind autotune_ctrl autotune_ctrl_assertions #(.n_others(n_others)) u_chk (
   .pclk, .presetn, .psel, .penable, .pready_ff, .pslverr_ff, .tuning_ff,
   .phase_ff, .speed_ref_pct_ff, .const_write_ff, .led_code_ff, .other_valid_ff);

// ---- sim/panel_model.sv ----
/*
 operator panel keys and external start terminal.
 assumes one-cycle press requests from the bench on pclk.
*/
`timescale 1ns/1ps
module panel_model
(
   input  wire logic pclk,
   input  wire logic press_fwd,
   input  wire logic press_stop,
   input  wire logic ext_on,
   output logic      forward_run_key,
   output logic      stop_key,
   output logic      forward_start_input
);
   logic [2:0] fwd_cnt_ff = 3'h0;
   logic [2:0] stop_cnt_ff = 3'h0;
   // keys held six cycles: the pin sync needs more than three
   always_ff @(posedge pclk)
   begin
      fwd_cnt_ff <= press_fwd ? 3'h6 : fwd_cnt_ff - (fwd_cnt_ff != 3'h0);
      stop_cnt_ff <= press_stop ? 3'h6 : stop_cnt_ff - (stop_cnt_ff != 3'h0);
   end
   assign forward_run_key = fwd_cnt_ff != 3'h0;
   assign stop_key = stop_cnt_ff != 3'h0;
   assign forward_start_input = ext_on;
endmodule

// ---- sim/autotune_ctrl_tb_top.sv ----
/*
 self-checking bench of autotune_ctrl over apb and panel keys.
 assumes shortened phase counts; 25 MHz pclk.
*/
`timescale 1ns/1ps
module autotune_ctrl_tb_top;
   import autotune_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_ff, q;
   logic        pready_ff, pslverr_ff, lerr, cw_seen = 0;
   logic        press_fwd = 0, press_stop = 0, ext_on = 0, thermal = 0, shutoff = 0;
   logic        forward_run_key, stop_key, forward_start_input;
   logic [3:0]  other_inputs = 4'h0, other_valid_ff, led_code_ff;
   logic        run_ff, tuning_ff, const_write_ff, banner_ff, irq_ff;
   logic        led_on_ff, trip_ff, shutoff_ff;
   logic [6:0]  phase_ff;
   logic [7:0]  speed_ref_pct_ff;
   int          bad_count = 0, num_checks = 0;
   always #20 pclk = ~pclk;
   always @(posedge pclk) if (const_write_ff === 1'b1) cw_seen <= 1'b1;
   panel_model u_panel (.pclk, .press_fwd, .press_stop, .ext_on, .forward_run_key,
      .stop_key, .forward_start_input);
   autotune_ctrl #(.hold_cyc(40), .exc_cyc(20), .rmp_cyc(20)) u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
      .pready_ff, .pslverr_ff, .forward_run_key, .reverse_run_key(1'b0), .stop_key,
      .forward_start_input, .reverse_start_input(1'b0),
      .external_thermal_trip_input(thermal), .output_shutoff_input(shutoff),
      .fault_clear_input(1'b0), .other_inputs, .run_ff, .reverse_ff(), .tuning_ff,
      .phase_ff, .speed_ref_pct_ff, .const_write_ff, .banner_ff, .led_code_ff,
      .led_on_ff, .other_valid_ff, .trip_ff, .shutoff_ff, .irq_ff);
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready_ff !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         $display("BAD pready expected 1 seen 0");
         test_done();
      end
      q = prdata_ff;
      lerr = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic key(input logic s);
      @(posedge pclk);
      if (s)
         press_stop <= 1'b1;
      else
         press_fwd <= 1'b1;
      @(posedge pclk);
      press_stop <= 1'b0;
      press_fwd <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask
   task automatic wait_code(input logic [3:0] c);
      int n;
      for (n = 0; n < 600 && led_code_ff !== c; n++)
         @(posedge pclk);
      chk("state code", c, led_code_ff);
      if (n >= 600)
         test_done();
   endtask
   task automatic start_tune;
      cw_seen <= 1'b0;
      apb(1, tune_off, 32'h1);
      key(0);
      wait_code(ts_running);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, led_off, 0);
      chk("led sel", 32'h1, q);
      chk("led on", 32'h1, led_on_ff);
      apb(1, src_off, 32'h3);
      apb(0, src_off, 0);
      chk("src locked", 32'h0, q);
      apb(1, wprot_off, 32'h321);
      apb(1, src_off, 32'h3);
      apb(0, src_off, 0);
      chk("src unlocked", 32'h3, q);
      for (int i = 41; i <= 47; i++)
      begin
         apb(1, par_adr_off, i);
         apb(1, par_dat_off, 32'hff00 + i);
      end
      apb(1, wprot_off, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1, wprot_off, 32'h321);
      for (int i = 41; i <= 47; i++)
      begin
         apb(1, par_adr_off, i);
         apb(0, par_dat_off, 0);
         chk("tuning data", 32'hff00 + i, q);
      end
      apb(1, src_off, 32'h1);
      apb(1, par_adr_off, 32'h0);
      apb(1, par_dat_off, 32'h1234);
      apb(0, par_dat_off, 0);
      chk("motor const", 32'h1234, q);
      apb(1, wprot_off, 32'h0);
      apb(0, par_dat_off, 0);
      chk("ordinary kept", 32'h0, q);
      apb(1, src_off, 32'h0);
      apb(0, 8'h2c, 0);
      chk("unmapped err", 32'h1, {31'h0, lerr});
      $display("test registers done");
      key(0);
      chk("plain run", 32'h1, {tuning_ff, run_ff});
      key(1);
      apb(1, ctrl_off, 32'h1);
      ext_on <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("ext run", 32'h1, run_ff);
      ext_on <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("ext stop", 32'h0, run_ff);
      apb(1, ctrl_off, 32'hc);
      other_inputs <= 4'hf;
      start_tune();
      chk("banner", 32'h1, banner_ff);
      chk("others masked", 32'h0, other_valid_ff);
      wait_code(ts_done);
      chk("commit", 32'h1, cw_seen);
      chk("run after end", 32'h1, run_ff);
      chk("irq raised", 32'h1, irq_ff);
      apb(1, irq_msk_off, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'h0, irq_ff);
      apb(1, irq_msk_off, 32'h0);
      apb(1, irq_st_off, 32'h1);
      apb(0, irq_st_off, 0);
      chk("irq cleared", 32'h0, q);
      key(1);
      chk("stopped", 32'h0, run_ff);
      $display("test full tuning done");
      start_tune();
      key(1);
      wait_code(ts_forced);
      chk("no commit forced", 32'h0, cw_seen);
      key(1);
      start_tune();
      thermal <= 1'b1;
      wait_code(ts_error);
      chk("no commit error", 32'h0, cw_seen);
      chk("trip copy", 32'h1, trip_ff);
      thermal <= 1'b0;
      key(1);
      chk("others live", 32'hf, other_valid_ff);
      apb(0, irq_st_off, 0);
      chk("irq fail", 32'h2, q);
      start_tune();
      shutoff <= 1'b1;
      wait_code(ts_forced);
      chk("no commit shutoff", 32'h0, cw_seen);
      chk("shutoff copy", 32'h1, shutoff_ff);
      shutoff <= 1'b0;
      key(1);
      $display("test abnormal ends done");
      test_done();
   end
endmodule
